//--- psdr_params.svh
`ifndef PSDR_PARAMS_SVH
`define PSDR_PARAMS_SVH

// Command-address word layout: six bytes, most significant first.
`define PSDR_CA_BYTES      3'd6
`define PSDR_CA_ROW_BYTES  3'd4
`define PSDR_CA_RW_BIT     47
`define PSDR_CA_SPACE_BIT  46
`define PSDR_CA_BURST_BIT  45
`define PSDR_CA_UPPER_HI   44
`define PSDR_CA_UPPER_LO   16
`define PSDR_CA_LOWER_HI   2

// Reset values.
`define PSDR_RST_BYTE      8'h00
`define PSDR_RST_WORD      16'h0000
`define PSDR_RST_CA        48'h0000_0000_0000

// Wrap masks (wrapped burst length in words minus one), selected by a two-bit code.
`define PSDR_WRAP_W16B     8'h07
`define PSDR_WRAP_W32B     8'h0f
`define PSDR_WRAP_W64B     8'h1f
`define PSDR_WRAP_W128B    8'h3f

`endif

//--- psdr_pkg.sv
package psdr_pkg;

  typedef enum logic [2:0] {
    PSDR_IDLE  = 3'b000,
    PSDR_CMD   = 3'b001,
    PSDR_LAT   = 3'b010,
    PSDR_RDATA = 3'b011,
    PSDR_WDATA = 3'b100,
    PSDR_DONE  = 3'b101
  } psdr_state_t;

  typedef struct packed {
    logic       is_read;
    logic       is_reg;
    logic       is_linear;
  } psdr_cmd_t;

  typedef struct packed {
    logic [3:0] latency;
    logic [1:0] wrap_sel;
  } psdr_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        is_reg;
    logic [1:0]  byte_en;
    logic [15:0] data;
  } psdr_wr_t;

endpackage : psdr_pkg

//--- psdr_device.sv
// Behaviour
// (R1) Register read: upper byte on strobe high.
// (R2) Write: upper byte rising, lower byte falling.
// (R3) Register space always big-endian.
// (R4) Master centres write data between edges.
// (R5) Latency writes: strobe high masks byte.
// (R6) Zero-latency writes: strobe released, full words. Only register writes get full words; memory writes use the strobe mask.
// (R7) Master selects with idle clock first.
// (R8) First word: read, space, burst type bits.
// (R9) Array access starts after first two words.
// (R10) Master honours read-write recovery time.
// (R11) Strobe high during command doubles latency.
// (R12) After latency, strobe and data start together.
// (R13) Data continues while clock toggles, select low.
// (R14) Strobe held low to pause between words.
// (R15) Wrapped bursts wrap; linear bursts run on.
// (R16) Reading past last address gives undefined data.
// (R17) Master ends reads only with idle clock.
// (R18) No dependence on clock outside transactions.
// (R19) Transactions start with true clock low.
// (R20) Complement clock only on low-voltage parts.
// (R21) Device alone drives strobe during reads.
// (R22) Master captures read bytes on strobe edges.
`include "psdr_params.svh"

module psdr_device #(
  parameter int ADDR_W = 23
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                cs_n,
  input  wire logic                bus_clk,
  input  wire logic                bus_clk_complement,
  input  wire logic [7:0]          dq_in,
  output logic      [7:0]          dq_out,
  output logic                     dq_oe_n,
  input  wire logic                rw_data_strobe_in,
  output logic                     rw_data_strobe_out,
  output logic                     rw_data_strobe_oe_n,
  input  wire psdr_pkg::psdr_cfg_t cfg,
  input  wire logic                extra_latency,
  output logic                     act_start,
  output psdr_pkg::psdr_cmd_t      cmd,
  output logic                     rd_req,
  output logic      [ADDR_W-1:0]   rd_addr,
  input  wire logic                rd_ack,
  input  wire logic [15:0]         rd_data,
  output psdr_pkg::psdr_wr_t       wr,
  output logic      [ADDR_W-1:0]   wr_addr
);

  // The wrap mask needs the low eight address bits, and a word address never exceeds 32 bits.
  initial begin
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("ADDR_W must lie between 8 and 32");
    end
  end

  // The bus runs far slower than clock; every pin but bus_clk_complement is synchronised, so edges of
  // bus_clk are seen a few cycles late but in order with the data beside them.
  logic [1:0] clk_sync;
  logic [1:0] cs_sync;
  logic [1:0] rw_data_strobe_sync;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic       clk_prev;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_sync  <= 2'h0;
      cs_sync   <= 2'h3;
      rw_data_strobe_sync <= 2'h0;
      dq_s1     <= `PSDR_RST_BYTE;
      dq_s2     <= `PSDR_RST_BYTE;
      clk_prev  <= 1'b0;
    end else begin
      clk_sync  <= {clk_sync[0], bus_clk};
      cs_sync   <= {cs_sync[0], cs_n};
      rw_data_strobe_sync <= {rw_data_strobe_sync[0], rw_data_strobe_in};
      dq_s1     <= dq_in;
      dq_s2     <= dq_s1;
      clk_prev  <= clk_sync[1];
    end
  end

  // The complement clock carries no extra information for a sampling design.
  logic clk_level;
  assign clk_level = clk_sync[1]; // see (R20)

  logic selected;
  logic rise;
  logic fall;
  assign selected = !cs_sync[1];
  // clk_prev resets to the idle level of bus_clk, so no false rise follows reset.
  assign rise     = selected && clk_level && !clk_prev;
  assign fall     = selected && !clk_level && clk_prev;

  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                   input logic             linear,
                                                   input logic [1:0]       sel);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = '0;
    unique case (sel)
      2'h0: mask[7:0] = `PSDR_WRAP_W16B;
      2'h1: mask[7:0] = `PSDR_WRAP_W32B;
      2'h2: mask[7:0] = `PSDR_WRAP_W64B;
      2'h3: mask[7:0] = `PSDR_WRAP_W128B;
    endcase
    inc = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    if (linear) begin
      next_addr = inc;
    end else begin
      next_addr = (a & ~mask) | (inc & mask);
    end
  endfunction : next_addr

  psdr_pkg::psdr_state_t state;
  logic [47:0]           ca;
  logic [2:0]            ca_edges;
  logic [4:0]            lat_cnt;
  logic                  long_lat;
  logic [4:0]            lat_target;
  logic [47:0]           ca_full;
  logic [ADDR_W-1:0]     start_addr;

  assign lat_target = long_lat ? {cfg.latency, 1'b0} : {1'b0, cfg.latency};
  assign ca_full    = {ca[39:0], dq_s2};
  assign start_addr = ADDR_W'({ca_full[`PSDR_CA_UPPER_HI:`PSDR_CA_UPPER_LO],
                               ca_full[`PSDR_CA_LOWER_HI:0]});

  // Decides where the transaction goes once the sixth byte has arrived.
  function automatic psdr_pkg::psdr_state_t after_cmd(input logic [47:0] w,
                                                      input logic [4:0]  lat);
    if (!w[`PSDR_CA_RW_BIT] && w[`PSDR_CA_SPACE_BIT]) begin
      after_cmd = psdr_pkg::PSDR_WDATA;
    end else if (lat == 5'h00) begin
      after_cmd = w[`PSDR_CA_RW_BIT] ? psdr_pkg::PSDR_RDATA : psdr_pkg::PSDR_WDATA;
    end else begin
      after_cmd = psdr_pkg::PSDR_LAT;
    end
  endfunction : after_cmd

  logic data_go;
  assign data_go = (state == psdr_pkg::PSDR_LAT) && rise && (lat_cnt == lat_target);

  // Transaction sequencing; deselect ends everything, whatever the bus clock does.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state    <= psdr_pkg::PSDR_IDLE;
      ca       <= `PSDR_RST_CA;
      ca_edges <= 3'h0;
      lat_cnt  <= 5'h00;
      long_lat <= 1'b0;
      cmd      <= '0;
    end else if (!selected) begin
      state    <= psdr_pkg::PSDR_IDLE; // see (R17) see (R18)
      ca_edges <= 3'h0;
      lat_cnt  <= 5'h00;
      long_lat <= extra_latency;
    end else begin
      unique case (state)
        psdr_pkg::PSDR_IDLE: begin
          state <= psdr_pkg::PSDR_CMD; // see (R7) see (R19)
        end
        psdr_pkg::PSDR_CMD: begin
          if (rise || fall) begin
            ca       <= ca_full;
            ca_edges <= ca_edges + 3'h1;
            if (ca_edges == `PSDR_CA_BYTES - 3'h1) begin
              cmd.is_read   <= ca_full[`PSDR_CA_RW_BIT]; // see (R8)
              cmd.is_reg    <= ca_full[`PSDR_CA_SPACE_BIT];
              cmd.is_linear <= ca_full[`PSDR_CA_BURST_BIT];
              state         <= after_cmd(ca_full, lat_target); // see (R11)
            end
          end
        end
        psdr_pkg::PSDR_LAT: begin
          // Only rising edges count; the rise that meets the target carries data.
          if (rise) begin
            lat_cnt <= lat_cnt + 5'h01;
          end
          if (data_go) begin
            state <= cmd.is_read ? psdr_pkg::PSDR_RDATA : psdr_pkg::PSDR_WDATA;
          end
        end
        psdr_pkg::PSDR_RDATA,
        psdr_pkg::PSDR_WDATA,
        psdr_pkg::PSDR_DONE: begin
          state <= state; // see (R13)
        end
        default: begin
          state <= psdr_pkg::PSDR_DONE;
        end
      endcase
    end
  end

  // Row and upper column are known after four bytes, so the array may open early.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      act_start <= 1'b0;
    end else begin
      act_start <= (state == psdr_pkg::PSDR_CMD) && (rise || fall) &&
                   (ca_edges == `PSDR_CA_ROW_BYTES - 3'h1); // see (R9)
    end
  end

  // Read path: one word is prefetched so a stall only shows as a held-low strobe.
  logic              fetch_en;
  logic              have_word;
  logic [15:0]       word;
  logic [7:0]        lo_byte;
  logic              lo_pending;

  // Gated by select so that no word is taken in the cycles after a deselect.
  assign fetch_en = selected && cmd.is_read &&
                    (state == psdr_pkg::PSDR_LAT || state == psdr_pkg::PSDR_RDATA);
  assign rd_req   = fetch_en && !have_word;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_addr     <= '0;
      have_word   <= 1'b0;
      word        <= `PSDR_RST_WORD;
    end else if (!selected) begin
      // A deselect drops the prefetched word; the next transaction fetches afresh.
      have_word   <= 1'b0;
    end else begin
      if (state == psdr_pkg::PSDR_CMD && (rise || fall) &&
          ca_edges == `PSDR_CA_BYTES - 3'h1) begin
        rd_addr <= start_addr;
      end
      if (rd_req && rd_ack) begin
        word      <= rd_data;
        have_word <= 1'b1;
        rd_addr   <= next_addr(rd_addr, cmd.is_linear, cfg.wrap_sel); // see (R15) see (R16)
      end else if (rise && have_word && !lo_pending &&
                   (data_go || state == psdr_pkg::PSDR_RDATA)) begin
        have_word <= 1'b0;
      end
    end
  end

  logic read_phase;
  logic drive_strobe;
  // Reading starts on the very rise that ends the latency, not one cycle later.
  assign read_phase = cmd.is_read && (data_go || state == psdr_pkg::PSDR_RDATA);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_out             <= `PSDR_RST_BYTE;
      lo_byte            <= `PSDR_RST_BYTE;
      lo_pending         <= 1'b0;
      rw_data_strobe_out <= 1'b0;
    end else if (state == psdr_pkg::PSDR_CMD || state == psdr_pkg::PSDR_IDLE) begin
      rw_data_strobe_out <= selected && long_lat; // see (R11)
      lo_pending         <= 1'b0;
    end else if (read_phase) begin
      if (rise && have_word && !lo_pending) begin
        dq_out             <= word[15:8]; // see (R1) see (R3) see (R12)
        lo_byte            <= word[7:0];
        lo_pending         <= 1'b1;
        rw_data_strobe_out <= 1'b1;
      end else if (fall && lo_pending) begin
        dq_out             <= lo_byte; // see (R1) see (R3)
        lo_pending         <= 1'b0;
        rw_data_strobe_out <= 1'b0;
      end else if (rise) begin
        // No word ready at a rise: the strobe stays low and dq holds, a pause for the master.
        rw_data_strobe_out <= 1'b0; // see (R14)
      end
    end else begin
      rw_data_strobe_out <= 1'b0;
    end
  end

  // The strobe is driven during command bytes and reads; for zero-latency writes
  // it is released, since the master leaves it floating there.
  assign drive_strobe = selected &&
                        (state == psdr_pkg::PSDR_CMD ||
                         (cmd.is_read && (state == psdr_pkg::PSDR_LAT ||
                                          state == psdr_pkg::PSDR_RDATA))); // see (R21) see (R6)

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rw_data_strobe_oe_n <= 1'b1;
      dq_oe_n             <= 1'b1;
    end else begin
      rw_data_strobe_oe_n <= !drive_strobe;
      // Data drive opens on the rise that ends the latency, together with the first byte.
      dq_oe_n             <= !(selected && cmd.is_read &&
                               (state == psdr_pkg::PSDR_RDATA || data_go)); // see (R12)
    end
  end

  // Write path: bytes are sampled mid-cell because the master centres them.
  logic       zero_lat;
  logic       hi_mask;
  logic [7:0] hi_byte;
  logic       hi_taken;
  logic       wr_phase;

  assign zero_lat = cmd.is_reg;
  assign wr_phase = !cmd.is_read &&
                    (state == psdr_pkg::PSDR_WDATA || data_go);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr       <= '0;
      wr_addr  <= '0;
      hi_byte  <= `PSDR_RST_BYTE;
      hi_mask  <= 1'b0;
      hi_taken <= 1'b0;
    end else begin
      wr.valid <= 1'b0;
      // Step the address once the word has been handed over, so wr_addr names it while valid.
      if (wr.valid) begin
        wr_addr <= next_addr(wr_addr, cmd.is_linear, cfg.wrap_sel); // see (R15)
      end
      if (!selected) begin
        hi_taken <= 1'b0;
      end else if (state == psdr_pkg::PSDR_CMD && (rise || fall) &&
                   ca_edges == `PSDR_CA_BYTES - 3'h1) begin
        wr_addr <= start_addr;
      end else if (wr_phase && rise) begin
        hi_byte  <= dq_s2; // see (R2) see (R4)
        // Register-space writes (zero_lat) ignore the strobe: they always write whole words.
        hi_mask  <= !zero_lat && rw_data_strobe_sync[1]; // see (R5)
        hi_taken <= 1'b1;
      end else if (wr_phase && fall && hi_taken) begin
        wr.valid   <= 1'b1;
        wr.is_reg  <= cmd.is_reg;
        wr.data    <= {hi_byte, dq_s2}; // see (R2) see (R3)
        wr.byte_en <= zero_lat ? 2'h3 : {!hi_mask, !rw_data_strobe_sync[1]}; // see (R5) see (R6)
        hi_taken   <= 1'b0;
      end
    end
  end

endmodule : psdr_device

//--- psdr_props.sv
module psdr_props #(
  parameter int ADDR_W = 23
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                cs_n,
  input wire logic [7:0]          dq_out,
  input wire logic                dq_oe_n,
  input wire logic                rw_data_strobe_out,
  input wire logic                rw_data_strobe_oe_n,
  input wire psdr_pkg::psdr_cfg_t cfg,
  input wire logic                act_start,
  input wire psdr_pkg::psdr_cmd_t cmd,
  input wire logic                rd_req,
  input wire logic [ADDR_W-1:0]   rd_addr,
  input wire logic                rd_ack,
  input wire psdr_pkg::psdr_wr_t  wr
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Five cycles cover the select synchroniser and the output register.
  bus_release_a: assert property (cs_n [*5] |-> dq_oe_n && rw_data_strobe_oe_n)
    else $error("bus driven while deselected");
  strobe_owner_a: assert property (!dq_oe_n |-> !rw_data_strobe_oe_n)
    else $error("read data without strobe drive");
  byte_edge_a: assert property (!dq_oe_n && !$past(dq_oe_n) && $changed(dq_out) |->
    $changed(rw_data_strobe_out)) else $error("read byte moved without strobe edge");
  act_pulse_a: assert property (act_start |=> !act_start)
    else $error("activate longer than one cycle");
  wr_pulse_a: assert property (wr.valid |=> !wr.valid)
    else $error("write word longer than one cycle");
  reg_write_a: assert property (wr.valid && wr.is_reg |->
    wr.byte_en == 2'b11 && rw_data_strobe_oe_n) else $error("register write masked");
  one_word_a: assert property (rd_req && rd_ack |=> !rd_req)
    else $error("second word requested too early");
  lin_step_a: assert property (rd_req && rd_ack && cmd.is_linear |=>
    rd_addr == $past(rd_addr) + 1'b1) else $error("linear address step wrong");
  wrap_step_a: assert property (rd_req && rd_ack && !cmd.is_linear && cfg.wrap_sel == 2'd0 |=>
    rd_addr[2:0] == $past(rd_addr[2:0]) + 3'd1 && $stable(rd_addr[ADDR_W-1:3]))
    else $error("wrapped address step wrong");

  cover property (wr.valid && wr.is_reg);
  cover property (rd_req && rd_ack && !cmd.is_linear);
  cover property (!rw_data_strobe_oe_n && $rose(rw_data_strobe_out));
endmodule : psdr_props

bind psdr_device psdr_props #(.ADDR_W(ADDR_W)) i_psdr_props (
  .clock(clock), .rst(rst), .cs_n(cs_n), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
  .rw_data_strobe_out(rw_data_strobe_out), .rw_data_strobe_oe_n(rw_data_strobe_oe_n),
  .cfg(cfg), .act_start(act_start), .cmd(cmd), .rd_req(rd_req), .rd_addr(rd_addr),
  .rd_ack(rd_ack), .wr(wr));

//--- psdr_master.sv
module psdr_master #(
  parameter int RECOVERY = 20
) (
  input  wire logic  clock,
  input  wire logic  st_out,
  input  wire logic  st_oe_n,
  output logic       cs_n,
  output logic       bus_clk,
  output logic       bus_clk_complement,
  output logic [7:0] dq,
  output logic       dq_en,
  output logic       st,
  output logic       st_en
);
  timeunit 1ns;
  timeprecision 1ns;
  int         first_k;
  logic [7:0] drv_dq;
  logic [7:0] idle_dq;
  logic       drv_st;
  logic       idle_st;

  assign bus_clk_complement = ~bus_clk;
  // Released lines keep changing so that a stale value is never mistaken for data.
  assign dq = dq_en ? drv_dq : idle_dq;
  assign st = st_en ? drv_st : idle_st;
  initial begin
    cs_n = 1'b1;
    bus_clk = 1'b0;
    drv_dq = 8'h00;
    idle_dq = 8'h5a;
    dq_en = 1'b0;
    drv_st = 1'b0;
    idle_st = 1'b0;
    st_en = 1'b0;
  end
  always @(posedge clock) begin
    #1;
    idle_dq = ~idle_dq;
    idle_st = ~idle_st;
  end

  // Data is set four cycles ahead of the edge, so it sits centred on it.
  task automatic step(input logic b, input logic [7:0] d, input logic de, input logic s,
                      input logic se);
    drv_dq = d;
    dq_en = de;
    drv_st = s;
    st_en = se;
    repeat (4) @(posedge clock);
    #1;
    bus_clk = b;
    repeat (5) @(posedge clock);
    #1;
  endtask : step

  task automatic xfer(input logic [47:0] ca, input int lat, input int nw,
                      input logic [31:0] wd, input logic [3:0] wm);
    int         w;
    logic       wrt;
    logic [15:0] d;
    logic [1:0] m;
    wrt = !ca[47];
    first_k = -1;
    repeat (RECOVERY) @(posedge clock);
    #1;
    cs_n = 1'b0;
    for (int i = 0; i < 6; i++) step(!i[0], ca[47 - 8 * i -: 8], 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < lat + nw; k++) begin
      w = k - lat;
      d = (wrt && w >= 0) ? wd[31 - 16 * w -: 16] : 16'h0000;
      m = (wrt && w >= 0) ? wm[3 - 2 * w -: 2] : 2'b00;
      step(1'b1, d[15:8], wrt && w >= 0, m[1], wrt && lat > 0);
      if (first_k < 0 && !st_oe_n && st_out) first_k = k;
      step(1'b0, d[7:0], wrt && w >= 0, m[0], wrt && lat > 0);
    end
    dq_en = 1'b0;
    st_en = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    cs_n = 1'b1;
  endtask : xfer
endmodule : psdr_master

//--- psdr_tb.sv
module psdr_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clock = 1'b0;
  logic                rst = 1'b1;
  logic                cs_n, bus_clk, bus_clk_c, m_st, s_out, s_oe_n, dq_oe_n, act_start, rd_req;
  logic                extra_latency = 1'b0;
  logic                rd_ack = 1'b0;
  logic                last_s = 1'b0;
  logic                lin;
  logic [7:0]          m_dq, dq_out, got[$];
  logic [15:0]         rd_data = 16'h0000;
  logic [15:0]         acked[$];
  logic [22:0]         rd_addr, wr_addr, waq[$];
  psdr_pkg::psdr_cfg_t cfg = '{latency: 4'd3, wrap_sel: 2'd0};
  psdr_pkg::psdr_cmd_t cmd;
  psdr_pkg::psdr_wr_t  wr, wq[$];
  int                  failures = 0, total_checks = 0, seed = 32'h849f, stall = 0, slow = 0;
  int                  exp_addr, acts = 0;

  always #20 clock = ~clock;

  psdr_device i_psdr_device (.clock(clock), .rst(rst), .cs_n(cs_n), .bus_clk(bus_clk),
    .bus_clk_complement(bus_clk_c), .dq_in(dq_oe_n ? m_dq : dq_out), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .rw_data_strobe_in(s_oe_n ? m_st : s_out), .rw_data_strobe_out(s_out),
    .rw_data_strobe_oe_n(s_oe_n), .cfg(cfg), .extra_latency(extra_latency),
    .act_start(act_start), .cmd(cmd), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
    .rd_data(rd_data), .wr(wr), .wr_addr(wr_addr));
  psdr_master i_psdr_master (.clock(clock), .st_out(s_out), .st_oe_n(s_oe_n), .cs_n(cs_n),
    .bus_clk(bus_clk), .bus_clk_complement(bus_clk_c), .dq(m_dq), .dq_en(), .st(m_st), .st_en());

  task automatic chk_num(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t count or address %0h, expected %0h", $time, g, e);
    end
  endtask : chk_num

  task automatic chk_data(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t data %0h, expected %0h", $time, g, e);
    end
  endtask : chk_data

  // The user side answers word requests, slowly when asked, to force strobe pauses.
  always @(posedge clock) begin
    #1;
    if (rd_ack) acked.push_back(rd_data);
    if (stall > 0) stall--;
    rd_ack = rd_req === 1'b1 && stall == 0 && !rd_ack;
    if (rd_ack) begin
      chk_num(rd_addr, exp_addr);
      exp_addr = lin ? (exp_addr + 1) % (1 << 23) : (exp_addr & ~7) | ((exp_addr + 1) & 7);
      rd_data = 16'($random(seed));
      stall = slow;
    end
  end
  always @(posedge clock) begin
    if (!dq_oe_n && s_out !== last_s) got.push_back(dq_out);
    last_s <= s_out;
  end
  always @(posedge clock) if (act_start === 1'b1) acts++;
  always @(posedge clock) if (wr.valid === 1'b1) begin
    wq.push_back(wr);
    waq.push_back(wr_addr);
  end

  task automatic run_read(input logic [47:0] ca, input int lat, input int nw);
    got.delete();
    acked.delete();
    lin = ca[45];
    exp_addr = {ca[35:16], ca[2:0]};
    acts = 0;
    i_psdr_master.xfer(ca, lat, nw, 32'h0000_0000, 4'h0);
    chk_num(acts, 1);
    chk_num(cmd, ca[47:45]);
    chk_num(i_psdr_master.first_k, lat);
    chk_num(got.size() >= 4, 1);
    for (int i = 0; i < got.size(); i++)
      chk_data({8'h00, got[i]}, {8'h00, i[0] ? acked[i / 2][7:0] : acked[i / 2][15:8]});
  endtask : run_read

  task automatic run_write(input logic [47:0] ca, input int lat, input logic [3:0] wm);
    logic [31:0] wd;
    logic [1:0]  be;
    logic [15:0] bm;
    wd = $random(seed);
    wq.delete();
    waq.delete();
    acts = 0;
    i_psdr_master.xfer(ca, lat, 2, wd, wm);
    chk_num(acts, 1);
    chk_num(cmd, ca[47:45]);
    chk_num(wq.size(), 2);
    for (int w = 0; w < wq.size() && w < 2; w++) begin
      be = ca[46] ? 2'b11 : ~wm[3 - 2 * w -: 2];
      bm = {{8{be[1]}}, {8{be[0]}}};
      chk_num(waq[w], {ca[35:16], ca[2:0]} + w);
      chk_num({wq[w].is_reg, wq[w].byte_en}, {ca[46], be});
      chk_data(wq[w].data & bm, wd[31 - 16 * w -: 16] & bm);
    end
  endtask : run_write

  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(40 * 20000);
    failures++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clock);
    run_read({3'b111, 13'h0000, 16'($random(seed)), 13'h0000, 3'($random(seed))}, 3, 4);
    extra_latency = 1'b1;
    slow = 30;
    run_read({3'b100, 13'h0000, 16'($random(seed)), 13'h0000, 3'h6}, 3 * 2, 10);
    slow = 0;
    run_write({3'b011, 13'h0000, 16'($random(seed)), 13'h0000, 3'($random(seed))}, 0, 4'h6);
    extra_latency = 1'b0;
    run_write({3'b001, 13'h0000, 16'($random(seed)), 13'h0000, 3'h2}, 3, 4'h9);
    stop_test();
  end
endmodule : psdr_tb
